// ---- phy_regs_pkg.sv ----
package phy_regs_pkg;

  // ----------------------------------------
  // register addresses on the management bus
  // ----------------------------------------
  localparam logic [4:0] ADDR_CONTROL_ONE = 5'h00;
  localparam logic [4:0] ADDR_STATUS_ONE = 5'h01;
  localparam logic [4:0] ADDR_IDENT_HIGH = 5'h02;
  localparam logic [4:0] ADDR_IDENT_LOW = 5'h03;
  localparam logic [4:0] ADDR_STATUS_TWO = 5'h11;
  localparam logic [4:0] ADDR_SILICON_REV = 5'h12;

  // ----------------------------------------
  // status word one field positions
  // ----------------------------------------
  localparam int FULL_DPX_CAP_BIT = 12;
  localparam int HALF_DPX_CAP_BIT = 11;
  localparam int LATCHED_LINK_BIT = 2;
  localparam int LATCHED_JABBER_BIT = 1;

  // ----------------------------------------
  // status word two field positions, and the control word one duplex bit
  // ----------------------------------------
  localparam int TX_ACTIVE_BIT = 13;
  localparam int RX_ACTIVE_BIT = 12;
  localparam int COLLISION_BIT = 11;
  localparam int LIVE_LINK_BIT = 10;
  localparam int DUPLEX_STATE_BIT = 9;
  localparam int POLARITY_BIT = 5;
  localparam int CTRL_DUPLEX_BIT = 8;

  // ----------------------------------------
  // identification values, all arbitrary
  // ----------------------------------------
  localparam logic [21:0] VENDOR_ID_BITS = 22'h2A_5A5A;
  localparam logic [5:0] PHY_PART_NUMBER = 6'h15;
  localparam logic [3:0] PHY_REVISION = 4'h3;
  localparam logic [4:0] SILICON_REVISION = 5'h06;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic LATCHED_LINK_RESET = 1'b0;
  localparam logic LATCHED_JABBER_RESET = 1'b0;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam real CLK_MHZ = 40.0;
  localparam real MGMT_OP_NS = 10240.0;
  localparam int MGMT_OP_CYCLES = int'(MGMT_OP_NS * CLK_MHZ / 1000.0);
  localparam logic [9:0] MGMT_OP_LAST = 10'(MGMT_OP_CYCLES - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} mgmt_state_e;

  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic collision;
    logic link_up;
    logic jabber_seen;
    logic polarity_reversed;
  } line_status_s;

  typedef struct packed {
    logic start_read;
    logic start_write;
    logic [4:0] addr;
  } mgmt_req_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] rdata;
  } mgmt_rsp_s;

endpackage

// ---- phy_op_timer.sv ----
`timescale 1ns/1ps
module phy_op_timer
  import phy_regs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  import phy_regs_pkg::*;

  typedef struct packed {
    logic busy;
    logic done;
    logic [9:0] count;
  } timer_s;

  timer_s state_q;
  timer_s state_d;

  // ----------------------------------------
  // operation timer
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    state_d.done = 1'b0;
    if (state_q.busy)
    begin
      if (state_q.count == MGMT_OP_LAST)
      begin
        state_d.busy = 1'b0;
        state_d.done = 1'b1;
        state_d.count = 10'h000;
      end
      else
      begin
        state_d.count = state_q.count + 10'h001;
      end
    end
    else if (start)
    begin
      state_d.busy = 1'b1;
      state_d.count = 10'h000;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign busy = state_q.busy;
  assign done = state_q.done;

endmodule

// ---- phy_status_identity_regs.sv ----
`timescale 1ns/1ps
module phy_status_identity_regs
  import phy_regs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // live line conditions
  input wire phy_regs_pkg::line_status_s line_status,
  // duplex control bit from control word one
  input wire logic ctrl_full_duplex,
  // management requests
  input wire phy_regs_pkg::mgmt_req_s mgmt_req,
  // management answers
  output phy_regs_pkg::mgmt_rsp_s mgmt_rsp,
  // silicon revision register
  output logic [4:0] silicon_revision_reg
);
  import phy_regs_pkg::*;

  typedef struct packed {
    mgmt_state_e state;
    logic busy;
    logic [4:0] addr;
    logic latched_link_flag;
    logic latched_jabber_flag;
    logic done;
    logic [15:0] rdata;
    logic [4:0] silicon_rev;
  } regs_s;

  regs_s state_q;
  regs_s state_d;
  logic timer_busy;
  logic timer_done;
  logic timer_start;
  logic rearm;
  logic [15:0] status_one;
  logic [15:0] status_two;
  logic [15:0] read_word;

  // ----------------------------------------
  // request acceptance
  // ----------------------------------------
  // one operation at a time; the timer must be idle too
  function automatic logic can_accept(
    input mgmt_state_e st,
    input logic tmr_busy
  );
    return (st == ST_IDLE) && !tmr_busy;
  endfunction

  // busy covers the whole operation, up to its done edge
  function automatic logic op_pending(
    input mgmt_state_e st
  );
    return st != ST_IDLE;
  endfunction

  // ----------------------------------------
  // status word one
  // ----------------------------------------
  // a loss or jabber seen this cycle already shows in the word
  function automatic logic [15:0] build_status_one(
    input logic link_latch,
    input logic jabber_latch,
    input line_status_s ls
  );
    logic [15:0] w;
    w = DATA_RESET;
    w[FULL_DPX_CAP_BIT] = 1'b1;
    w[HALF_DPX_CAP_BIT] = 1'b1;
    w[LATCHED_LINK_BIT] = link_latch & ls.link_up;
    w[LATCHED_JABBER_BIT] = jabber_latch | ls.jabber_seen;
    return w;
  endfunction

  // ----------------------------------------
  // status word two
  // ----------------------------------------
  // live levels only; nothing here is latched
  function automatic logic [15:0] build_status_two(
    input line_status_s ls,
    input logic full_duplex
  );
    logic [15:0] w;
    w = DATA_RESET;
    w[TX_ACTIVE_BIT] = ls.tx_active;
    w[RX_ACTIVE_BIT] = ls.rx_active;
    w[COLLISION_BIT] = ls.collision;
    w[LIVE_LINK_BIT] = ls.link_up;
    w[DUPLEX_STATE_BIT] = full_duplex;
    w[POLARITY_BIT] = ls.polarity_reversed;
    return w;
  endfunction

  // ----------------------------------------
  // identification words
  // ----------------------------------------
  // constants only, so a write has nothing to land in
  function automatic logic [15:0] ident_word(
    input logic [4:0] addr
  );
    logic [15:0] w;
    w = DATA_RESET;
    case (addr)
      ADDR_IDENT_HIGH: w = VENDOR_ID_BITS[21:6];
      ADDR_IDENT_LOW: w = {VENDOR_ID_BITS[5:0], PHY_PART_NUMBER,
        PHY_REVISION};
      default: w = DATA_RESET;
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // read multiplexer
  // ----------------------------------------
  // unknown addresses read zero rather than alias a word
  function automatic logic [15:0] pick_word(
    input logic [4:0] addr,
    input logic [15:0] s1,
    input logic [15:0] s2
  );
    logic [15:0] w;
    w = DATA_RESET;
    case (addr)
      ADDR_STATUS_ONE: w = s1;
      ADDR_STATUS_TWO: w = s2;
      ADDR_IDENT_HIGH: w = ident_word(addr);
      ADDR_IDENT_LOW: w = ident_word(addr);
      default: w = DATA_RESET;
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // latch updates
  // ----------------------------------------
  // link latch: one cycle with the link down clears it
  function automatic logic next_link_latch(
    input logic latch,
    input logic link_up,
    input logic rearm_now
  );
    logic v;
    v = latch;
    if (!link_up)
    begin
      v = 1'b0;
    end
    // rearm takes the live level, so a loss now stays low
    if (rearm_now)
    begin
      v = link_up;
    end
    return v;
  endfunction

  // jabber latch: set wins over a rearm in the same cycle
  function automatic logic next_jabber_latch(
    input logic latch,
    input logic jabber,
    input logic rearm_now
  );
    logic v;
    v = latch;
    if (jabber)
    begin
      v = 1'b1;
    end
    if (rearm_now)
    begin
      v = jabber;
    end
    return v;
  endfunction

  // ----------------------------------------
  // word assembly
  // ----------------------------------------
  always_comb
  begin
    status_one = build_status_one(state_q.latched_link_flag,
      state_q.latched_jabber_flag, line_status);
    status_two = build_status_two(line_status, ctrl_full_duplex);
    read_word = pick_word(state_q.addr, status_one, status_two);
  end

  // ----------------------------------------
  // management sequencer
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    state_d.done = 1'b0;
    timer_start = 1'b0;
    state_d.silicon_rev = SILICON_REVISION;
    // only a completed read of status word one rearms
    rearm = (state_q.state == ST_READ) && timer_done
      && (state_q.addr == ADDR_STATUS_ONE);
    case (state_q.state)
      ST_IDLE:
      begin
        // requests while busy are dropped, host must wait
        if (mgmt_req.start_read && can_accept(state_q.state, timer_busy))
        begin
          state_d.state = ST_READ;
          state_d.addr = mgmt_req.addr;
          timer_start = 1'b1;
        end
        else if (mgmt_req.start_write
          && can_accept(state_q.state, timer_busy))
        begin
          state_d.state = ST_WRITE;
          timer_start = 1'b1;
        end
      end
      ST_READ:
      begin
        if (timer_done)
        begin
          state_d.state = ST_IDLE;
          state_d.done = 1'b1;
          state_d.rdata = read_word;
        end
      end
      ST_WRITE:
      begin
        // status and identity words hold no writable state
        if (timer_done)
        begin
          state_d.state = ST_IDLE;
          state_d.done = 1'b1;
        end
      end
      default: state_d.state = ST_IDLE;
    endcase
    state_d.latched_link_flag = next_link_latch(state_q.latched_link_flag,
      line_status.link_up, rearm);
    state_d.latched_jabber_flag = next_jabber_latch(
      state_q.latched_jabber_flag, line_status.jabber_seen, rearm);
    state_d.busy = op_pending(state_d.state);
  end

  // ----------------------------------------
  // operation timer
  // ----------------------------------------
  phy_op_timer u_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(timer_start),
    .busy(timer_busy),
    .done(timer_done)
  );

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q.state <= ST_IDLE;
      state_q.busy <= 1'b0;
      state_q.addr <= 5'h00;
      state_q.latched_link_flag <= LATCHED_LINK_RESET;
      state_q.latched_jabber_flag <= LATCHED_JABBER_RESET;
      state_q.done <= 1'b0;
      state_q.rdata <= DATA_RESET;
      state_q.silicon_rev <= 5'h00;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every answer comes straight from the state register
  assign mgmt_rsp.busy = state_q.busy;
  assign mgmt_rsp.done = state_q.done;
  assign mgmt_rsp.rdata = state_q.rdata;
  assign silicon_revision_reg = state_q.silicon_rev;

endmodule

// ---- phy_status_identity_regs_properties.sv ----
`timescale 1ns/1ps
module phy_regs_checker
  import phy_regs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // watched ports
  input wire phy_regs_pkg::line_status_s line_status,
  input wire logic ctrl_full_duplex,
  input wire phy_regs_pkg::mgmt_req_s mgmt_req,
  input wire phy_regs_pkg::mgmt_rsp_s mgmt_rsp,
  input wire logic [4:0] silicon_revision_reg
);
  import phy_regs_pkg::*;
  // ----------------------------------------
  // request tracking
  // ----------------------------------------
  logic take;
  logic rd1;
  logic rd2;
  logic wr_q;
  logic [4:0] addr_q;
  logic link_d1;
  logic jab_d1;
  logic link_hist;
  logic jab_hist;
  assign take = !mgmt_rsp.busy
    && (mgmt_req.start_read || mgmt_req.start_write);
  assign rd1 = mgmt_rsp.done && !wr_q && addr_q == ADDR_STATUS_ONE;
  assign rd2 = mgmt_rsp.done && !wr_q && addr_q == ADDR_STATUS_TWO;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_q <= 5'h00;
      wr_q <= 1'b0;
    end
    else if (take)
    begin
      addr_q <= mgmt_req.addr;
      wr_q <= !mgmt_req.start_read;
    end
  end
  // latch history as the rules describe it, rearmed by status one reads
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link_d1 <= 1'b0;
      jab_d1 <= 1'b0;
      link_hist <= 1'b0;
      jab_hist <= 1'b0;
    end
    else
    begin
      link_d1 <= line_status.link_up;
      jab_d1 <= line_status.jabber_seen;
      if (rd1)
      begin
        link_hist <= link_d1 & line_status.link_up;
        jab_hist <= jab_d1 | line_status.jabber_seen;
      end
      else
      begin
        link_hist <= link_hist & line_status.link_up;
        jab_hist <= jab_hist | line_status.jabber_seen;
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  AST_BUSY_RISE: assert property (take |=> mgmt_rsp.busy [*8])
    else $error("busy not held after request");
  AST_DONE_TIME: assert property (take |-> ##[405:415] mgmt_rsp.done)
    else $error("operation did not finish in time");
  AST_DONE_PULSE: assert property (mgmt_rsp.done |=> !mgmt_rsp.done)
    else $error("done longer than one cycle");
  AST_STATUS_ONE: assert property (
    rd1 |-> mgmt_rsp.rdata[15:3] == 13'h0300 && !mgmt_rsp.rdata[0])
    else $error("status one fixed bits wrong");
  AST_LINK_LATCH: assert property (
    rd1 |-> mgmt_rsp.rdata[LATCHED_LINK_BIT] == link_hist)
    else $error("latched link flag wrong");
  AST_JABBER_LATCH: assert property (
    rd1 |-> mgmt_rsp.rdata[LATCHED_JABBER_BIT] == jab_hist)
    else $error("latched jabber flag wrong");
  AST_STATUS_TWO: assert property (
    rd2 |-> mgmt_rsp.rdata[13:10] ==
    {$past(line_status.tx_active), $past(line_status.rx_active),
    $past(line_status.collision), $past(line_status.link_up)}
    && mgmt_rsp.rdata[15:14] == 2'h0 && mgmt_rsp.rdata[8:6] == 3'h0
    && mgmt_rsp.rdata[4:0] == 5'h00) else $error("status two wrong");
  AST_DUPLEX: assert property (
    rd2 |-> mgmt_rsp.rdata[9] == $past(ctrl_full_duplex))
    else $error("duplex bit wrong");
  AST_POLARITY: assert property (
    rd2 |-> mgmt_rsp.rdata[5] == $past(line_status.polarity_reversed))
    else $error("polarity bit wrong");
  AST_IDENT: assert property (
    mgmt_rsp.done && !wr_q && addr_q == ADDR_IDENT_HIGH
    |-> mgmt_rsp.rdata == VENDOR_ID_BITS[21:6])
    else $error("ident high wrong");
  AST_WRITE_QUIET: assert property (
    mgmt_rsp.done && wr_q |-> $stable(mgmt_rsp.rdata))
    else $error("write changed read data");
  AST_SILICON: assert property (
    $past(resetn) |-> silicon_revision_reg == SILICON_REVISION)
    else $error("silicon revision wrong");
  cover property (rd1 && mgmt_rsp.rdata[1]);
  cover property (rd2 && mgmt_rsp.rdata[9]);
  cover property (mgmt_rsp.done && wr_q);
endmodule
bind phy_status_identity_regs phy_regs_checker chk (.sys_clk(sys_clk),
  .resetn(resetn), .line_status(line_status),
  .ctrl_full_duplex(ctrl_full_duplex), .mgmt_req(mgmt_req),
  .mgmt_rsp(mgmt_rsp), .silicon_revision_reg(silicon_revision_reg));

// ---- mgmt_host_model.sv ----
`timescale 1ns/1ps
module mgmt_host_model
  import phy_regs_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // bench commands
  input wire logic go,
  input wire logic wr,
  input wire logic [4:0] op_addr,
  // management bus
  input wire phy_regs_pkg::mgmt_rsp_s mgmt_rsp,
  output phy_regs_pkg::mgmt_req_s mgmt_req
);
  import phy_regs_pkg::*;
  logic issue;
  assign issue = go && !mgmt_rsp.busy;
  initial mgmt_req = '0;
  always @(negedge sys_clk)
  begin
    mgmt_req.start_read <= issue && !wr;
    mgmt_req.start_write <= issue && wr;
    // idle address flips so a stale value never looks valid
    mgmt_req.addr <= issue ? op_addr : ~mgmt_req.addr;
  end
endmodule

// ---- phy_status_identity_regs_tb_top.sv ----
`timescale 1ns/1ps
module phy_status_identity_regs_tb_top;
  import phy_regs_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  line_status_s line_status = '0;
  logic ctrl_full_duplex = 1'b0;
  mgmt_req_s mgmt_req;
  mgmt_rsp_s mgmt_rsp;
  logic [4:0] silicon_revision_reg;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [4:0] op_addr = 5'h00;
  logic [15:0] notes[$];
  logic [15:0] last = 16'h0000;
  logic [15:0] exp;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 66054;
  always #12.5 sys_clk = ~sys_clk;
  phy_status_identity_regs dut (.sys_clk(sys_clk), .resetn(resetn),
    .line_status(line_status), .ctrl_full_duplex(ctrl_full_duplex),
    .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
    .silicon_revision_reg(silicon_revision_reg));
  mgmt_host_model host (.sys_clk(sys_clk), .go(go), .wr(wr),
    .op_addr(op_addr), .mgmt_rsp(mgmt_rsp), .mgmt_req(mgmt_req));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(string what, logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // writes leave read data standing, so a write notes the last value
  task op(logic w, logic [4:0] a, logic [15:0] e);
    int n;
    notes.push_back(w ? last : e);
    last = w ? last : e;
    @(negedge sys_clk);
    go <= 1'b1;
    wr <= w;
    op_addr <= a;
    @(negedge sys_clk);
    go <= 1'b0;
    n = 0;
    while (mgmt_rsp.done !== 1'b1 && n < 500)
    begin
      @(negedge sys_clk);
      n++;
    end
    // an operation that never finishes is a failure, not a hang
    if (mgmt_rsp.done !== 1'b1)
    begin
      miscompares++;
      summarize;
    end
  endtask
  // ----------------------------------------
  // monitor and watchdog
  // ----------------------------------------
  always @(negedge sys_clk)
    if (mgmt_rsp.done === 1'b1 && notes.size() > 0)
      check("rdata", notes.pop_front(), mgmt_rsp.rdata);
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    line_status.link_up = 1'b1;
    op(1'b0, ADDR_STATUS_ONE, 16'h1800);
    op(1'b0, ADDR_STATUS_ONE, 16'h1804);
    @(negedge sys_clk);
    line_status.link_up = 1'b0;
    @(negedge sys_clk);
    line_status.link_up = 1'b1;
    op(1'b0, ADDR_STATUS_ONE, 16'h1800);
    line_status.jabber_seen = 1'b1;
    @(negedge sys_clk);
    line_status.jabber_seen = 1'b0;
    op(1'b1, ADDR_STATUS_ONE, 16'h0000);
    op(1'b0, ADDR_STATUS_ONE, 16'h1806);
    op(1'b0, ADDR_STATUS_ONE, 16'h1804);
    op(1'b0, ADDR_IDENT_HIGH, VENDOR_ID_BITS[21:6]);
    op(1'b0, ADDR_IDENT_LOW, {VENDOR_ID_BITS[5:0], PHY_PART_NUMBER,
      PHY_REVISION});
    op(1'b0, 5'h1F, 16'h0000);
    check("silicon", {11'h000, SILICON_REVISION},
      {11'h000, silicon_revision_reg});
    repeat (12)
    begin
      // jabber kept low here so the latch does not disturb later reads
      line_status = 6'($random(seed)) & 6'h3D;
      ctrl_full_duplex = 1'($random(seed));
      exp = {2'h0, line_status.tx_active, line_status.rx_active,
        line_status.collision, line_status.link_up, ctrl_full_duplex,
        3'h0, line_status.polarity_reversed, 5'h00};
      op(1'b0, ADDR_STATUS_TWO, exp);
    end
    // let the monitor take the last answer before the verdict
    @(negedge sys_clk);
    check("notes left", 16'h0000, 16'(notes.size()));
    summarize;
  end
endmodule
